// ### logic/emb_bus_controller.sv
`default_nettype none
`include "emb_defines.svh"
module emb_bus_controller
  import emb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic [23:0] addr_in,
  input wire logic [1:0] size_in,
  input wire logic [31:0] wdata_in,
  input wire logic [`EMB_WAIT_W-1:0] wait_flash_in,
  input wire logic [`EMB_WAIT_W-1:0] wait_ram_in,
  input wire logic [`EMB_WAIT_W-1:0] wait_rom2_in,
  input wire logic wide_flash_in,
  input wire logic wide_ram_in,
  input wire logic wide_rom2_in,
  input wire logic rom2_present_in,
  input wire logic rom2_gpo_in,
  input wire logic spare_gpo_in,
  input wire logic sleep_in,
  input wire logic [15:0] ext_data_line_in,
  input wire logic [31:0] sys_rdata_in,
  input wire logic eeprom_clock_low_in,
  input wire logic eeprom_data_low_in,
  input wire logic eeprom_write_protect_low_in,
  input wire logic eeprom_data_pin_in,
  output logic ack_out,
  output logic [31:0] rdata_out,
  output logic sys_select_out,
  output logic [`EMB_ADDR_W-1:0] ext_address_line_out,
  output logic [15:0] ext_data_line_out,
  output logic ext_data_lo_oe_n_out,
  output logic ext_data_hi_oe_n_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out,
  output logic program_rom_select_n_out,
  output logic work_ram_select_n_out,
  output logic extra_rom_select_n_out,
  output logic spare_nvm_select_n_out,
  output logic low_byte_select_n_out,
  output logic system_reset_out_n_out,
  output logic ext_read_dir_out,
  output logic eeprom_clock_pin_oe_n_out,
  output logic eeprom_data_pin_oe_n_out,
  output logic eeprom_write_protect_pin_oe_n_out,
  output logic eeprom_data_pin_level_out
);
  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  emb_state_e state_r;
  emb_area_t area_r;
  logic write_r;
  logic wide_r;
  logic [2:0] beats_r;
  logic [2:0] beat_r;
  logic [23:0] addr_r;
  logic [31:0] wdata_r;
  logic [31:0] rbuf_r;
  logic wait_done;
  emb_area_t area_dec;
  logic in_range;
  logic wide_sel;
  logic [`EMB_WAIT_W-1:0] wait_sel;
  logic [2:0] bytes_n;
  logic [2:0] beats_nxt;
  logic [23:0] cur_addr;
  logic [7:0] cur_byte;
  logic [15:0] cur_half;
  logic load_wait;
  assign area_dec = addr_in[`EMB_AREA_SEL_HI:`EMB_AREA_SEL_LO];
  // Flash spans 1M words, RAM 128k words; anything above folds out of range.
  assign in_range = (area_dec == `EMB_AREA_FLASH) ? (addr_in[21:1] < 21'(`EMB_FLASH_WORDS)) :
    (area_dec == `EMB_AREA_RAM) ? (addr_in[21:1] < 21'(`EMB_RAM_WORDS)) : 1'b1;
  assign wide_sel = (area_dec == `EMB_AREA_FLASH) ? wide_flash_in :
    (area_dec == `EMB_AREA_RAM) ? wide_ram_in : wide_rom2_in;
  assign wait_sel = (area_r == `EMB_AREA_FLASH) ? wait_flash_in :
    (area_r == `EMB_AREA_RAM) ? wait_ram_in : wait_rom2_in;
  assign bytes_n = (size_in == `EMB_SIZE_BYTE) ? 3'h1 :
    (size_in == `EMB_SIZE_HALF) ? 3'h2 : 3'h4;
  // Double word is handled like a word: one request of four bytes.
  assign beats_nxt = (wide_sel && bytes_n != 3'h1) ? (bytes_n >> 1) : bytes_n;
  assign cur_addr = wide_r ? (addr_r + {20'h0, beat_r, 1'b0}) : (addr_r + {21'h0, beat_r});
  assign cur_byte = wdata_r[{beat_r[1:0], 3'h0} +: 8];
  assign cur_half = wdata_r[{beat_r[0], 4'h0} +: 16];
  assign load_wait = (state_r == EMB_SETUP);
  emb_wait_cnt u_wait (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .load_in(load_wait),
    .value_in(wait_sel),
    .expired_out(wait_done)
  );
  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= EMB_IDLE;
      area_r <= `EMB_AREA_FLASH;
      write_r <= 1'b0;
      wide_r <= 1'b0;
      beats_r <= 3'h0;
      beat_r <= 3'h0;
      addr_r <= 24'h000000;
      wdata_r <= 32'h00000000;
      rbuf_r <= 32'h00000000;
      ack_out <= 1'b0;
      rdata_out <= 32'h00000000;
    end
    else
    begin
      ack_out <= 1'b0;
      case (state_r)
        EMB_IDLE:
          if (req_in && in_range)
          begin
            area_r <= area_dec;
            write_r <= write_in;
            wide_r <= wide_sel;
            beats_r <= beats_nxt;
            beat_r <= 3'h0;
            addr_r <= addr_in;
            wdata_r <= wdata_in;
            rbuf_r <= 32'h00000000;
            state_r <= EMB_SETUP;
          end
          else if (req_in)
          begin
            ack_out <= 1'b1;
            rdata_out <= 32'h00000000;
          end
        EMB_SETUP:
          state_r <= EMB_STROBE;
        EMB_STROBE:
          if (wait_done)
          begin
            if (area_r == `EMB_AREA_SYS)
              rbuf_r <= sys_rdata_in;
            else if (wide_r)
              rbuf_r[{beat_r[0], 4'h0} +: 16] <= ext_data_line_in;
            else
              rbuf_r[{beat_r[1:0], 3'h0} +: 8] <= ext_data_line_in[7:0];
            state_r <= EMB_NEXT;
          end
        EMB_NEXT:
          if (beat_r + 3'h1 < beats_r && area_r != `EMB_AREA_SYS)
          begin
            beat_r <= beat_r + 3'h1;
            state_r <= EMB_SETUP;
          end
          else
            state_r <= EMB_DONE;
        EMB_DONE:
        begin
          ack_out <= 1'b1;
          rdata_out <= rbuf_r;
          state_r <= EMB_IDLE;
        end
        default:
          state_r <= EMB_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  logic active;
  logic strobe_on;
  assign active = (state_r == EMB_SETUP) || (state_r == EMB_STROBE) || (state_r == EMB_NEXT);
  assign strobe_on = (state_r == EMB_SETUP) || (state_r == EMB_STROBE && !wait_done);
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ext_address_line_out <= '0;
      ext_data_line_out <= 16'h0000;
      ext_data_lo_oe_n_out <= 1'b1;
      ext_data_hi_oe_n_out <= 1'b1;
      read_strobe_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      program_rom_select_n_out <= 1'b1;
      work_ram_select_n_out <= 1'b1;
      extra_rom_select_n_out <= 1'b1;
      spare_nvm_select_n_out <= 1'b1;
      low_byte_select_n_out <= 1'b1;
      system_reset_out_n_out <= 1'b0;
      sys_select_out <= 1'b0;
      ext_read_dir_out <= 1'b1;
      eeprom_clock_pin_oe_n_out <= 1'b1;
      eeprom_data_pin_oe_n_out <= 1'b1;
      eeprom_write_protect_pin_oe_n_out <= 1'b1;
      eeprom_data_pin_level_out <= 1'b1;
    end
    else
    begin
      // In 16-bit mode the address counts words, in 8-bit mode bytes.
      // The area bits above the byte address never reach the address lines.
      ext_address_line_out <= wide_r ? {1'b0, cur_addr[21:1]} : cur_addr[21:0];
      ext_data_line_out <= wide_r ? cur_half : {8'h00, cur_byte};
      ext_data_lo_oe_n_out <= !(active && write_r && area_r != `EMB_AREA_SYS);
      ext_data_hi_oe_n_out <= !(active && write_r && wide_r && area_r != `EMB_AREA_SYS);
      ext_read_dir_out <= !(active && write_r);
      read_strobe_n_out <= !(strobe_on && !write_r && area_r != `EMB_AREA_SYS);
      write_strobe_n_out <= !(strobe_on && write_r && area_r != `EMB_AREA_SYS);
      program_rom_select_n_out <= !(active && area_r == `EMB_AREA_FLASH);
      work_ram_select_n_out <= !(active && area_r == `EMB_AREA_RAM);
      extra_rom_select_n_out <= rom2_present_in ?
        !(active && area_r == `EMB_AREA_ROM2) : rom2_gpo_in;
      spare_nvm_select_n_out <= spare_gpo_in;
      low_byte_select_n_out <= !(active && wide_r && area_r != `EMB_AREA_SYS);
      // Held low while asleep so the flash sits in power-down.
      system_reset_out_n_out <= !sleep_in;
      sys_select_out <= active && area_r == `EMB_AREA_SYS;
      // Open-drain lines: the enable goes low only to pull a line down.
      eeprom_clock_pin_oe_n_out <= !eeprom_clock_low_in;
      eeprom_data_pin_oe_n_out <= !eeprom_data_low_in;
      eeprom_write_protect_pin_oe_n_out <= !eeprom_write_protect_low_in;
      eeprom_data_pin_level_out <= eeprom_data_pin_in;
    end
  end
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_setup;
    state_r == EMB_SETUP;
  endsequence
  sequence s_strobe_lo;
    !read_strobe_n_out || !write_strobe_n_out;
  endsequence
  AST_ONE_SELECT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $countones({~program_rom_select_n_out, ~work_ram_select_n_out,
    ~(extra_rom_select_n_out | ~rom2_present_in)}) <= 1)
    else $error("More than one chip select active.");
  AST_STROBE_WAIT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_setup ##0 (area_r != `EMB_AREA_SYS)) |=> s_strobe_lo)
    else $error("Strobe not asserted after setup.");
  AST_SPARE_GPO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rst_n_in |=> spare_nvm_select_n_out == $past(spare_gpo_in))
    else $error("Spare select does not follow its output bit.");
  AST_SLEEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sleep_in |=> !system_reset_out_n_out)
    else $error("System reset not low in sleep.");
  AST_HI_INPUT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !wide_r |=> ext_data_hi_oe_n_out)
    else $error("Upper byte driven in 8-bit mode.");
  AST_LOBYTE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_r == EMB_IDLE) |=> low_byte_select_n_out)
    else $error("Low byte select active while idle.");
  AST_ACK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_r == EMB_DONE) |=> ack_out)
    else $error("Missing acknowledge.");
  AST_ROM2_GPO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rst_n_in && !rom2_present_in) |=> extra_rom_select_n_out == $past(rom2_gpo_in))
    else $error("Extra select does not follow its output bit.");
  AST_NVM_DATA: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rst_n_in |=> eeprom_data_pin_oe_n_out == !$past(eeprom_data_low_in))
    else $error("Serial data line enable does not follow its drive bit.");
endmodule // emb_bus_controller
`default_nettype wire

// ### logic/emb_defines.svh
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH
`define EMB_ADDR_W 22
`define EMB_DATA_W 16
`define EMB_AREA_SEL_HI 23
`define EMB_AREA_SEL_LO 22
`define EMB_AREA_FLASH 2'h0
`define EMB_AREA_RAM 2'h1
`define EMB_AREA_ROM2 2'h2
`define EMB_AREA_SYS 2'h3
`define EMB_FLASH_WORDS 22'h100000
`define EMB_RAM_WORDS 22'h020000
`define EMB_WAIT_W 4
`define EMB_SIZE_BYTE 2'h0
`define EMB_SIZE_HALF 2'h1
`define EMB_SIZE_WORD 2'h2
`define EMB_SIZE_DWORD 2'h3
`endif

// ### logic/emb_pkg.sv
`default_nettype none
`include "emb_defines.svh"
package emb_pkg;
  typedef enum logic [2:0] {EMB_IDLE, EMB_SETUP, EMB_STROBE, EMB_NEXT, EMB_DONE} emb_state_e;
  typedef logic [1:0] emb_area_t;
endpackage
`default_nettype wire

// ### logic/emb_wait_cnt.sv
`default_nettype none
`include "emb_defines.svh"
module emb_wait_cnt
  import emb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [`EMB_WAIT_W-1:0] value_in,
  output logic expired_out
);
  logic [`EMB_WAIT_W-1:0] cnt_r;
  // Each programmed wait state holds the strobe for one extra cycle.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      cnt_r <= '0;
    else if (load_in)
      cnt_r <= value_in;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - `EMB_WAIT_W'(1);
  end
  assign expired_out = (cnt_r == '0) && !load_in;
endmodule // emb_wait_cnt
`default_nettype wire

// ### verif/emb_bus_controller_bench.sv
`default_nettype none
`include "emb_defines.svh"
module emb_bus_controller_bench;
  import emb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rst_n_in, req_in, write_in, sleep_in, ack_out, sys_select_out;
  logic wide_flash_in, wide_ram_in, rom2_present_in, rom2_gpo_in, spare_gpo_in;
  logic [23:0] addr_in;
  logic [1:0] size_in;
  logic [31:0] wdata_in, rdata_out, rd;
  logic [3:0] wait_flash_in, wait_ram_in;
  logic [15:0] mem_data, data_out;
  logic [21:0] addr_out;
  logic lo_oe_n, hi_oe_n, rd_n, wr_n, rom_n, ram_n, x_n, sp_n, lb_n, rst_out_n, dir;
  logic scl_lo, sda_lo, wp_lo, scl_oe_n, sda_oe_n, wp_oe_n, sda_seen;
  logic [2:0] nvm;
  int mismatches, total_checks, strb, multi, hioe, oe, dirw, lbs, sel;
  emb_bus_controller DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req_in),
    .write_in(write_in), .addr_in(addr_in), .size_in(size_in), .wdata_in(wdata_in),
    .wait_flash_in(wait_flash_in), .wait_ram_in(wait_ram_in), .wait_rom2_in(4'h1),
    .wide_flash_in(wide_flash_in), .wide_ram_in(wide_ram_in), .wide_rom2_in(1'b1),
    .rom2_present_in(rom2_present_in), .rom2_gpo_in(rom2_gpo_in),
    .spare_gpo_in(spare_gpo_in), .sleep_in(sleep_in), .ext_data_line_in(mem_data),
    .sys_rdata_in(32'h1234ABCD), .eeprom_clock_low_in(scl_lo),
    .eeprom_data_low_in(sda_lo), .eeprom_write_protect_low_in(wp_lo),
    .eeprom_data_pin_in(nvm[0]), .ack_out(ack_out), .rdata_out(rdata_out),
    .sys_select_out(sys_select_out), .ext_address_line_out(addr_out),
    .ext_data_line_out(data_out), .ext_data_lo_oe_n_out(lo_oe_n),
    .ext_data_hi_oe_n_out(hi_oe_n), .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n),
    .program_rom_select_n_out(rom_n), .work_ram_select_n_out(ram_n),
    .extra_rom_select_n_out(x_n), .spare_nvm_select_n_out(sp_n),
    .low_byte_select_n_out(lb_n), .system_reset_out_n_out(rst_out_n),
    .ext_read_dir_out(dir), .eeprom_clock_pin_oe_n_out(scl_oe_n),
    .eeprom_data_pin_oe_n_out(sda_oe_n), .eeprom_write_protect_pin_oe_n_out(wp_oe_n),
    .eeprom_data_pin_level_out(sda_seen));
  emb_mem_model mem (.clk_in(clk_in), .addr_in(addr_out), .data_in(data_out),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .rom_sel_n_in(rom_n), .ram_sel_n_in(ram_n),
    .scl_oe_n_in(scl_oe_n), .sda_oe_n_in(sda_oe_n), .wp_oe_n_in(wp_oe_n),
    .data_out(mem_data), .nvm_lines_out(nvm));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // ------------------------------
  // One access, held until acknowledged.
  // ------------------------------
  task automatic access(input logic w, input logic [23:0] a, input logic [1:0] sz,
    input logic [31:0] d);
    int n;
    strb = 0;
    multi = 0;
    hioe = 0;
    oe = 0;
    dirw = 0;
    lbs = 0;
    sel = 0;
    @(posedge clk_in);
    write_in <= w;
    addr_in <= a;
    size_in <= sz;
    wdata_in <= d;
    req_in <= 1'b1;
    for (n = 0; n < 400; n++)
    begin
      @(posedge clk_in);
      #1;
      if (!rd_n || !wr_n) strb++;
      if (!rom_n && !ram_n) multi++;
      if (!hi_oe_n) hioe++;
      if (!lo_oe_n) oe++;
      if (!dir) dirw++;
      if (!lb_n) lbs++;
      if (sys_select_out) sel++;
      if (ack_out === 1'b1) break;
    end
    req_in <= 1'b0;
    if (n == 400)
    begin
      mismatches++;
      conclude();
    end
    else rd = rdata_out;
  endtask
  task automatic t_reset();
    repeat (7) @(posedge clk_in);
    #1;
    check("strobes", {rd_n, wr_n}, 2'h3);
    check("nvm released", nvm, 3'h7);
    check("selects", {rom_n, ram_n, x_n}, 3'h7);
    check("spare", sp_n, 1'h1);
    check("low byte", lb_n, 1'h1);
    check("hi oe", hi_oe_n, 1'h1);
    check("sys reset", rst_out_n, 1'h0);
    check("address", addr_out, 22'h0);
    @(posedge clk_in) rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check("sys reset run", rst_out_n, 1'h1);
    check("spare gpo", sp_n, 1'h0);
    check("nvm data idle", sda_seen, 1'h1);
  endtask
  task automatic t_ram();
    access(1'b1, 24'h400010, `EMB_SIZE_WORD, 32'hA5C31E77);
    check("wr strobe", strb, 6);
    check("one select", multi, 0);
    check("wr lo oe", oe, 10);
    check("wr dir", dirw, 10);
    check("wr hi oe", hioe, 10);
    check("wr low byte", lbs, 10);
    check("ram address", addr_out, 22'h000009);
    access(1'b0, 24'h400010, `EMB_SIZE_WORD, 32'h0);
    check("ram word", rd, 32'hA5C31E77);
    check("rd strobe", strb, 6);
    check("rd drivers", oe + dirw + hioe, 0);
    access(1'b0, 24'h400010, `EMB_SIZE_DWORD, 32'h0);
    check("ram dword", rd, 32'hA5C31E77);
    access(1'b0, 24'h440000, `EMB_SIZE_HALF, 32'h0);
    check("ram range", rd, 32'h0);
    check("ram range strobe", strb, 0);
    wide_ram_in <= 1'b0;
    access(1'b1, 24'h400020, `EMB_SIZE_BYTE, 32'h5A);
    check("narrow strobe", strb, 3);
    check("narrow hi oe", hioe, 0);
    check("narrow low byte", lbs, 0);
    access(1'b0, 24'h400020, `EMB_SIZE_BYTE, 32'h0);
    check("narrow byte", rd[7:0], 8'h5A);
  endtask
  task automatic t_flash();
    access(1'b0, 24'h000006, `EMB_SIZE_HALF, 32'h0);
    check("flash half", rd[15:0], 16'hF003);
    check("flash strobe", strb, 6);
    access(1'b0, 24'h200000, `EMB_SIZE_HALF, 32'h0);
    check("flash range", rd, 32'h0);
    check("flash range strobe", strb, 0);
    access(1'b0, 24'hC00000, `EMB_SIZE_WORD, 32'h0);
    check("system data", rd, 32'h1234ABCD);
    check("system select", sel, 4);
    check("system strobe", strb, 0);
  endtask
  task automatic t_gpo();
    rom2_present_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    check("rom2 gpo low", x_n, 1'h0);
    @(posedge clk_in) sleep_in <= 1'b1;
    rom2_gpo_in <= 1'b1;
    sda_lo <= 1'b1;
    wp_lo <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check("rom2 gpo high", x_n, 1'h1);
    check("nvm lines", nvm, 3'h2);
    check("nvm data in", sda_seen, 1'h0);
    check("sleep reset", rst_out_n, 1'h0);
  endtask
  initial
  begin
    {rst_n_in, req_in, write_in, sleep_in, rom2_gpo_in, spare_gpo_in} = '0;
    {scl_lo, sda_lo, wp_lo} = '0;
    {wide_flash_in, wide_ram_in, rom2_present_in} = 3'h7;
    addr_in = '0;
    size_in = '0;
    wdata_in = '0;
    wait_flash_in = 4'h5;
    wait_ram_in = 4'h2;
    mismatches = 0;
    total_checks = 0;
    t_reset();
    t_ram();
    t_flash();
    t_gpo();
    conclude();
  end
endmodule // emb_bus_controller_bench
`default_nettype wire

// ### verif/emb_mem_model.sv
`default_nettype none
// ------------------------------
// Flash and work RAM on the bus.
// ------------------------------
module emb_mem_model
(
  input wire logic clk_in,
  input wire logic [21:0] addr_in,
  input wire logic [15:0] data_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic rom_sel_n_in,
  input wire logic ram_sel_n_in,
  input wire logic scl_oe_n_in,
  input wire logic sda_oe_n_in,
  input wire logic wp_oe_n_in,
  output logic [15:0] data_out,
  output logic [2:0] nvm_lines_out
);
  logic [15:0] mem [0:63];
  logic [15:0] last;
  wire ram_rd = !rd_n_in && !ram_sel_n_in;
  wire rom_rd = !rd_n_in && !rom_sel_n_in;
  always @(posedge clk_in)
  begin
    if (!ram_sel_n_in && !wr_n_in) mem[addr_in[5:0]] <= data_in;
    if (ram_rd || rom_rd) last <= data_out;
  end
  // Pull-ups hold a released serial line high; a driven line reads low.
  assign nvm_lines_out = {wp_oe_n_in, scl_oe_n_in, sda_oe_n_in};
  // A released bus shows the inverse of the last value driven, never a stale copy.
  assign data_out = ram_rd ? mem[addr_in[5:0]] : rom_rd ? {4'hF, addr_in[11:0]} : ~last;
endmodule // emb_mem_model
`default_nettype wire
